// ---- inc/mca_bank_pkg.sv ----
// shared constants, offsets and carrier types of the error bank
package mca_bank_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_LO_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_HI_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;

	// ----------------------------------------------------------------
	// status field positions and widths
	// ----------------------------------------------------------------
	localparam int ERROR_CODE_LSB = 0;
	localparam int MODEL_CODE_LSB = 16;
	localparam int L3_CODE_LSB = 16;
	localparam int L3_RSVD_LSB = 19;
	localparam int L3_FIXED_LSB = 21;
	localparam int EXTRA_INFO_LSB = 32;
	localparam int EXTRA_INFO_MSB = 56;
	localparam int COUNT_LSB = 32;
	localparam int COUNT_WIDTH = 8;
	localparam int FORMAT_LSB = 40;
	localparam int SYNDROME_LSB = 44;
	localparam int SYNDROME_VALID_BIT = 52;
	localparam int HEALTH_LSB = 53;
	localparam int PCC_BIT = 57;
	localparam int ADDR_VALID_BIT = 58;
	localparam int EXTRA_DETAIL_VALID_BIT = 59;
	localparam int ENABLED_BIT = 60;
	localparam int UNCORRECTED_BIT = 61;
	localparam int OVERFLOW_BIT = 62;
	localparam int STATUS_VALID_BIT = 63;

	// ----------------------------------------------------------------
	// fixed values, masks and reset values
	// ----------------------------------------------------------------
	localparam logic [10:0] L3_FIXED_PATTERN = 11'b0010_0000_000;
	localparam logic [1:0] L3_RSVD_VALUE = 2'h0;
	// software may write everything but the count and reserved bits
	localparam logic [63:0] STATUS_WRITE_MASK = 64'hFE7F_F300_FFFF_FFFF;
	localparam logic [63:0] STATUS_READ_MASK = 64'hFE7F_F300_FFFF_FFFF;
	localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam int IRQ_WIDTH = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam int IRQ_LOGGED = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_SATURATED = 2;
	localparam int IRQ_UNCORRECTED = 3;

	// ----------------------------------------------------------------
	// health encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] HEALTH_NO_TRACKING = 2'h0;
	localparam logic [1:0] HEALTH_GREEN = 2'h1;
	localparam logic [1:0] HEALTH_YELLOW = 2'h2;
	localparam logic [1:0] HEALTH_RESERVED = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

	typedef struct packed {
		logic valid;
		logic uncorrected;
		logic enabled;
		logic pcc;
		logic addr_valid;
		logic extra_detail_valid;
		logic [1:0] extra_detail_format;
		logic syndrome_supplied;
		logic [7:0] syndrome;
		logic [1:0] health;
		logic cache_error;
		logic [2:0] l3_code;
		logic [15:0] model_code;
		logic [15:0] error_code;
	} log_event_type;

endpackage : mca_bank_pkg

// ---- logic/mca_bank_error_info_fields.sv ----
// error status bank: extra-info fields, cache error code and register port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - extra-info field sits in status bits 56:32, same layout for all types
// - bits 39:32 count correctable events since the last cold reset
// - count reads 1 after first event, increments, sticks at 255
// - bits 41:40 give extra-detail register format, meaningful with its valid flag
// - correctable ecc event puts its syndrome in bits 51:44
// - bit 52 set when a logged correctable ecc event supplies a syndrome
// - bits 54:53 health: 00 none, 01 green, 10 yellow, 11 reserved
// - health meaningful only with bit 63; undefined when bit 61 set
// - cache errors: 18:16 multi-way codes 000-011, 20:19 zero, fixed 31:21
// - cache errors: 18:16 codes 100-111 for single way and mixed cases
// - hardware sets valid flag on logging; only software clears it
module mca_bank_error_info_fields (
	input wire logic mclk,
	input wire logic resetn,
	input wire mca_bank_pkg::bus_req_type bus,
	output logic [31:0] rdata,
	input wire mca_bank_pkg::log_event_type log_event,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [63:0] bank_four_error_status;
	logic [63:0] next_status;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic [3:0] next_irq_status;
	logic [7:0] event_count;
	logic count_at_max;
	logic count_was_max;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit

	wire wr_lo = bus.wr && hit(bus.addr, mca_bank_pkg::STATUS_LO_OFFSET);
	wire wr_hi = bus.wr && hit(bus.addr, mca_bank_pkg::STATUS_HI_OFFSET);
	wire wr_irq = bus.wr && hit(bus.addr, mca_bank_pkg::IRQ_STATUS_OFFSET);
	wire wr_mask = bus.wr && hit(bus.addr, mca_bank_pkg::IRQ_MASK_OFFSET);

	// ----------------------------------------------------------------
	// correctable event counter
	// ----------------------------------------------------------------
	// every correctable event counts, even one that is not written in
	wire correctable_event = log_event.valid && !log_event.uncorrected;

	sat_counter #(
		.WIDTH(mca_bank_pkg::COUNT_WIDTH)
	) u_count (
		.mclk(mclk),
		.resetn(resetn),
		.inc(correctable_event),
		.count(event_count),
		.at_max(count_at_max)
	);

	// ----------------------------------------------------------------
	// overwrite policy
	// ----------------------------------------------------------------
	// a held uncorrected entry is never replaced; anything else is
	wire old_valid = bank_four_error_status[mca_bank_pkg::STATUS_VALID_BIT];
	wire old_uncorrected =
		bank_four_error_status[mca_bank_pkg::UNCORRECTED_BIT];
	wire log_write = log_event.valid && (!old_valid || !old_uncorrected);
	wire log_overflow = log_event.valid && old_valid;

	// ----------------------------------------------------------------
	// model specific code
	// ----------------------------------------------------------------
	// cache errors carry the way code plus a fixed pattern; others pass
	wire [15:0] cache_model_code = {mca_bank_pkg::L3_FIXED_PATTERN,
		mca_bank_pkg::L3_RSVD_VALUE,
		log_event.l3_code};
	wire [15:0] model_code = log_event.cache_error ? cache_model_code :
		log_event.model_code;

	// ----------------------------------------------------------------
	// syndrome and health
	// ----------------------------------------------------------------
	// syndrome is only kept for a correctable event that offers one
	wire syndrome_valid = !log_event.uncorrected &&
		log_event.syndrome_supplied;
	wire [7:0] syndrome = syndrome_valid ? log_event.syndrome : 8'h00;
	// the health code is stored as given; under an uncorrected entry it
	// is undefined, so software must not trust it then
	wire [1:0] health = log_event.health;

	// ----------------------------------------------------------------
	// new status word
	// ----------------------------------------------------------------
	// count bits stay zero here; the live count is merged on read
	wire [63:0] log_word = {
		1'b1,
		log_overflow,
		log_event.uncorrected,
		log_event.enabled,
		log_event.extra_detail_valid,
		log_event.addr_valid,
		log_event.pcc,
		2'h0,
		health,
		syndrome_valid,
		syndrome,
		2'h0,
		log_event.extra_detail_format,
		8'h00,
		model_code,
		log_event.error_code
	};

	// ----------------------------------------------------------------
	// status next value
	// ----------------------------------------------------------------
	// a hardware log wins over a software write in the same cycle, and
	// overflow is raised even when the new entry is dropped
	wire [63:0] sw_word = {
		wr_hi ? (bus.wdata & mca_bank_pkg::STATUS_WRITE_MASK[63:32]) :
			bank_four_error_status[63:32],
		wr_lo ? bus.wdata : bank_four_error_status[31:0]
	};
	wire [63:0] over_bit = 64'h1 << mca_bank_pkg::OVERFLOW_BIT;
	wire [63:0] valid_bit = 64'h1 << mca_bank_pkg::STATUS_VALID_BIT;
	assign next_status = log_write ? log_word :
		(log_overflow ? (sw_word | over_bit | valid_bit) : sw_word);

	// status register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bank_four_error_status <= mca_bank_pkg::STATUS_RESET;
		end else begin
			bank_four_error_status <= next_status;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	wire saturate_event = count_at_max && !count_was_max;
	wire [3:0] irq_events = {
		log_write && log_event.uncorrected,
		saturate_event,
		log_overflow,
		log_write
	};
	// new events win over a write-one clear in the same cycle
	assign next_irq_status = (irq_status &
		~(wr_irq ? bus.wdata[3:0] : 4'h0)) | irq_events;
	assign irq = |(irq_status & irq_mask);

	// interrupt registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_status <= mca_bank_pkg::IRQ_RESET;
			irq_mask <= mca_bank_pkg::IRQ_RESET;
			count_was_max <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= wr_mask ? bus.wdata[3:0] : irq_mask;
			count_was_max <= count_at_max;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// the live count replaces bits 39:32 and reserved bits mask to zero
	wire [63:0] status_view = (bank_four_error_status &
		mca_bank_pkg::STATUS_READ_MASK) |
		({56'h0, event_count} << mca_bank_pkg::COUNT_LSB);
	wire [31:0] read_mux =
		hit(bus.addr, mca_bank_pkg::STATUS_LO_OFFSET) ? status_view[31:0] :
		hit(bus.addr, mca_bank_pkg::STATUS_HI_OFFSET) ? status_view[63:32] :
		hit(bus.addr, mca_bank_pkg::IRQ_STATUS_OFFSET) ? {28'h0, irq_status} :
		hit(bus.addr, mca_bank_pkg::IRQ_MASK_OFFSET) ? {28'h0, irq_mask} :
		32'h0000_0000;

	// read data register; zero outside the answer cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= bus.rd ? read_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_first_event;
		correctable_event && (event_count == 8'h00);
	endsequence

	sequence s_read_hi;
		bus.rd && hit(bus.addr, mca_bank_pkg::STATUS_HI_OFFSET);
	endsequence

	property p_count_first;
		@(posedge mclk) disable iff (!resetn)
		s_first_event |=> (event_count == 8'h01);
	endproperty
	a_count_first: assert property (p_count_first)
		else $error("count not one after first correctable event");

	property p_count_step;
		@(posedge mclk) disable iff (!resetn)
		(correctable_event && event_count != 8'hFF) |=>
			(event_count == $past(event_count) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step on correctable event");

	property p_count_saturate;
		@(posedge mclk) disable iff (!resetn)
		(event_count == 8'hFF) |=> (event_count == 8'hFF);
	endproperty
	a_count_saturate: assert property (p_count_saturate)
		else $error("count left 255");

	property p_count_read;
		@(posedge mclk) disable iff (!resetn)
		s_read_hi |=>
			(rdata[7:0] == $past(event_count));
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("count bits do not show the counter");

	property p_reserved_zero;
		@(posedge mclk) disable iff (!resetn)
		s_read_hi |=> (rdata[11:10] == 2'h0) && (rdata[24:23] == 2'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved status bits read nonzero");

	property p_syndrome;
		@(posedge mclk) disable iff (!resetn)
		(log_write && !log_event.uncorrected &&
			log_event.syndrome_supplied) |=>
			bank_four_error_status[mca_bank_pkg::SYNDROME_VALID_BIT] &&
			(bank_four_error_status[51:44] == $past(log_event.syndrome));
	endproperty
	a_syndrome: assert property (p_syndrome)
		else $error("syndrome or its valid bit not captured");

	property p_no_syndrome_uncorrected;
		@(posedge mclk) disable iff (!resetn)
		(log_write && log_event.uncorrected) |=>
			!bank_four_error_status[mca_bank_pkg::SYNDROME_VALID_BIT];
	endproperty
	a_no_syndrome_uncorrected: assert property (p_no_syndrome_uncorrected)
		else $error("syndrome valid set for uncorrected entry");

	property p_cache_code;
		@(posedge mclk) disable iff (!resetn)
		(log_write && log_event.cache_error) |=>
			(bank_four_error_status[31:21] == mca_bank_pkg::L3_FIXED_PATTERN) &&
			(bank_four_error_status[20:19] == 2'h0) &&
			(bank_four_error_status[18:16] == $past(log_event.l3_code));
	endproperty
	a_cache_code: assert property (p_cache_code)
		else $error("cache error code field malformed");

	property p_fields;
		@(posedge mclk) disable iff (!resetn)
		log_write |=>
			(bank_four_error_status[54:53] == $past(log_event.health)) &&
			(bank_four_error_status[41:40] ==
				$past(log_event.extra_detail_format));
	endproperty
	a_fields: assert property (p_fields)
		else $error("health or format field not captured");

	property p_valid_set;
		@(posedge mclk) disable iff (!resetn)
		log_event.valid |=>
			bank_four_error_status[mca_bank_pkg::STATUS_VALID_BIT];
	endproperty
	a_valid_set: assert property (p_valid_set)
		else $error("valid flag not set after logging");

	property p_valid_kept;
		@(posedge mclk) disable iff (!resetn)
		(old_valid && !wr_hi) |=>
			bank_four_error_status[mca_bank_pkg::STATUS_VALID_BIT];
	endproperty
	a_valid_kept: assert property (p_valid_kept)
		else $error("valid flag cleared without software write");

	property p_reserved_stored;
		@(posedge mclk) disable iff (!resetn)
		(bank_four_error_status[43:42] == 2'h0) &&
			(bank_four_error_status[56:55] == 2'h0);
	endproperty
	a_reserved_stored: assert property (p_reserved_stored)
		else $error("reserved status bits hold a one");

	// the held entry below bit 62 must survive a dropped event untouched
	property p_held_entry;
		@(posedge mclk) disable iff (!resetn)
		(log_overflow && !log_write && !wr_hi && !wr_lo) |=>
			$stable(bank_four_error_status[61:0]);
	endproperty
	a_held_entry: assert property (p_held_entry)
		else $error("held uncorrected entry was overwritten");

	property p_overflow;
		@(posedge mclk) disable iff (!resetn)
		log_overflow |=>
			bank_four_error_status[mca_bank_pkg::OVERFLOW_BIT];
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow flag not set on a second entry");

	// a write-one clear takes effect unless a new entry lands beside it
	property p_irq_clear;
		@(posedge mclk) disable iff (!resetn)
		(wr_irq && bus.wdata[mca_bank_pkg::IRQ_LOGGED] &&
			!log_write) |=>
			!irq_status[mca_bank_pkg::IRQ_LOGGED];
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("write-one clear left the logged bit set");

	property p_saturate_irq;
		@(posedge mclk) disable iff (!resetn)
		saturate_event |=> irq_status[mca_bank_pkg::IRQ_SATURATED];
	endproperty
	a_saturate_irq: assert property (p_saturate_irq)
		else $error("reaching the count ceiling raised no status bit");

	property p_irq_level;
		@(posedge mclk) disable iff (!resetn)
		(log_write && irq_mask[mca_bank_pkg::IRQ_LOGGED] && !wr_mask) |=>
			irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("unmasked log event raised no interrupt");

endmodule : mca_bank_error_info_fields
`default_nettype wire

// ---- logic/sat_counter.sv ----
// saturating event counter, cleared only by reset
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic inc,
	output logic [WIDTH-1:0] count,
	output logic at_max
);

	localparam logic [WIDTH-1:0] MAX_COUNT = '1;
	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

	logic [WIDTH-1:0] next_count;

	// stop at all ones so a burst of events never wraps to a small count
	assign at_max = (count == MAX_COUNT);
	assign next_count = (inc && !at_max) ? count + ONE : count;

	// counter register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule : sat_counter
`default_nettype wire

// ---- testbench/mca_bank_error_info_fields_tb.sv ----
// self-checking bench for the error status bank
`timescale 1ns/1ps
`default_nettype none
module mca_bank_error_info_fields_tb;
	logic mclk;
	logic resetn;
	mca_bank_pkg::bus_req_type bus;
	mca_bank_pkg::log_event_type ev;
	logic [31:0] rdata;
	logic irq;
	int err_count;
	int tests_run;
	int exp_cnt;
	logic [31:0] rd_val;

	mca_bank_error_info_fields dut (
		.mclk(mclk),
		.resetn(resetn),
		.bus(bus),
		.rdata(rdata),
		.log_event(ev),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// clock, compare and bus helpers
	// ------------------------------------------------------------
	// 125 MHz core clock
	always #4 mclk = ~mclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : bus_wr

	// read data stands only in the cycle after the strobe edge
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	// ------------------------------------------------------------
	// event helpers and expected words
	// ------------------------------------------------------------
	function automatic mca_bank_pkg::log_event_type mk(input logic c,
		input logic [2:0] code, input logic [7:0] s, input logic [1:0] h);
		mk = '0;
		mk.valid = 1'b1;
		mk.extra_detail_valid = 1'b1;
		mk.extra_detail_format = h;
		mk.syndrome_supplied = 1'b1;
		mk.syndrome = s;
		mk.health = h;
		mk.cache_error = c;
		mk.l3_code = code;
		mk.model_code = 16'hC002;
		mk.error_code = 16'h010B;
	endfunction : mk

	function automatic logic [31:0] hi_exp(input mca_bank_pkg::log_event_type e);
		logic sv;
		sv = e.syndrome_supplied & ~e.uncorrected;
		hi_exp = {e.valid, 1'b0, e.uncorrected, e.enabled, e.extra_detail_valid,
			e.addr_valid, e.pcc, 2'b00, e.health, sv, sv ? e.syndrome : 8'h00,
			2'b00, e.extra_detail_format, exp_cnt[7:0]};
	endfunction : hi_exp

	task automatic log_one(input mca_bank_pkg::log_event_type e);
		@(posedge mclk);
		ev <= e;
		@(posedge mclk);
		ev <= '0;
		if (!e.uncorrected)
			exp_cnt = (exp_cnt < 255) ? exp_cnt + 1 : 255;
	endtask : log_one

	// clearing the bank first keeps overflow out of the expected word
	task automatic log_and_check(input mca_bank_pkg::log_event_type e);
		logic [31:0] lo;
		lo = e.cache_error ? {11'h100, 2'b00, e.l3_code, e.error_code}
			: {e.model_code, e.error_code};
		bus_wr(mca_bank_pkg::STATUS_HI_OFFSET, 32'h0000_0000);
		log_one(e);
		bus_rd(mca_bank_pkg::STATUS_LO_OFFSET, rd_val);
		check(rd_val, lo);
		bus_rd(mca_bank_pkg::STATUS_HI_OFFSET, rd_val);
		check(rd_val, hi_exp(e));
	endtask : log_and_check

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		for (int a = 0; a < 5; a++) begin
			bus_rd(8'(a * 4), rd_val);
			check(rd_val, 32'h0000_0000);
		end
	endtask : t_reset

	// first event reads 1; every health and format code, syndrome cases
	task automatic t_fields;
		mca_bank_pkg::log_event_type e;
		for (int h = 0; h < 4; h++)
			log_and_check(mk(1'b0, 3'h0, 8'(8'hA5 ^ h), 2'(h)));
		e = mk(1'b0, 3'h0, 8'h3C, 2'h1);
		e.syndrome_supplied = 1'b0;
		log_and_check(e);
		e = mk(1'b0, 3'h0, 8'h5A, 2'h2);
		e.uncorrected = 1'b1;
		e.enabled = 1'b1;
		e.pcc = 1'b1;
		log_and_check(e);
	endtask : t_fields

	// all eight cache codes with the same extra-info layout
	task automatic t_cache;
		for (int c = 0; c < 8; c++)
			log_and_check(mk(1'b1, 3'(c), 8'(c * 17), 2'(c)));
	endtask : t_cache

	// count and reserved bits resist writes; a held uncorrected entry
	// survives a new event while the count still moves
	task automatic t_sw;
		bus_wr(mca_bank_pkg::STATUS_LO_OFFSET, 32'h1234_5678);
		bus_wr(mca_bank_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF);
		bus_rd(mca_bank_pkg::STATUS_HI_OFFSET, rd_val);
		check(rd_val, 32'hFE7F_F300 | 32'(exp_cnt));
		log_one(mk(1'b1, 3'h6, 8'h44, 2'h1));
		bus_rd(mca_bank_pkg::STATUS_LO_OFFSET, rd_val);
		check(rd_val, 32'h1234_5678);
		bus_rd(mca_bank_pkg::STATUS_HI_OFFSET, rd_val);
		check(rd_val, 32'hFE7F_F300 | 32'(exp_cnt));
		bus_wr(mca_bank_pkg::STATUS_HI_OFFSET, 32'h0000_0000);
		bus_rd(mca_bank_pkg::STATUS_HI_OFFSET, rd_val);
		check(rd_val, 32'(exp_cnt));
	endtask : t_sw

	task automatic t_irq;
		bus_wr(mca_bank_pkg::IRQ_STATUS_OFFSET, 32'h0000_000F);
		bus_wr(mca_bank_pkg::IRQ_MASK_OFFSET, 32'h0000_0001);
		log_one(mk(1'b0, 3'h0, 8'h11, 2'h1));
		#1;
		check({31'h0, irq}, 32'h0000_0001);
		bus_rd(mca_bank_pkg::IRQ_STATUS_OFFSET, rd_val);
		check(rd_val & 32'h0000_0001, 32'h0000_0001);
		bus_wr(mca_bank_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001);
		#1;
		check({31'h0, irq}, 32'h0000_0000);
		bus_wr(mca_bank_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
		log_one(mk(1'b0, 3'h0, 8'h22, 2'h1));
		#1;
		check({31'h0, irq}, 32'h0000_0000);
	endtask : t_irq

	// back-to-back events drive the counter past its ceiling
	task automatic t_sat;
		for (int i = 0; i < 260; i++) begin
			@(posedge mclk);
			ev <= mk(1'b0, 3'h0, 8'h01, 2'h1);
		end
		@(posedge mclk);
		ev <= '0;
		exp_cnt = 255;
		bus_rd(mca_bank_pkg::STATUS_HI_OFFSET, rd_val);
		check(rd_val & 32'h0000_00FF, 32'h0000_00FF);
		bus_rd(mca_bank_pkg::IRQ_STATUS_OFFSET, rd_val);
		check(rd_val & 32'h0000_0004, 32'h0000_0004);
		log_and_check(mk(1'b1, 3'h5, 8'h77, 2'h2));
	endtask : t_sat

	// ------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic close_out;
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// the tests need about 440 cycles; some 45 times that means a hang
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		close_out();
	end

	// reset for 16 cycles, then run every scenario in turn
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		bus = '0;
		ev = '0;
		err_count = 0;
		tests_run = 0;
		exp_cnt = 0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_fields();
		t_cache();
		t_sw();
		t_irq();
		t_sat();
		close_out();
	end
endmodule : mca_bank_error_info_fields_tb
`default_nettype wire
